//--- clock_supervisor_pkg.sv
package clock_supervisor_pkg;

    // ------------------------------------------------------------------
    // timing
    // ------------------------------------------------------------------
    localparam int CLK_PERIOD_NS    = 100;        // pclk at 10 MHz
    localparam int WDT_BASE_TIME_NS = 4_000_000;  // 4 ms base period
    localparam int WDT_BASE_CYCLES  = WDT_BASE_TIME_NS / CLK_PERIOD_NS;
    localparam int SAMPLE_DIV_W     = 6;          // divide by 64
    localparam logic [SAMPLE_DIV_W-1:0] SAMPLE_RISE_CNT = 6'h1f;
    localparam logic [SAMPLE_DIV_W-1:0] SAMPLE_FALL_CNT = 6'h3f;
    localparam int POSTSCALE_W      = 16;

    // ------------------------------------------------------------------
    // bus and register map
    // ------------------------------------------------------------------
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam logic [7:0] WDT_CTRL_OFFSET    = 8'h00;
    localparam logic [7:0] OSC_CTRL_OFFSET    = 8'h04;
    localparam logic [7:0] IRQ2_OFFSET        = 8'h08;
    localparam logic [7:0] RESET_CAUSE_OFFSET = 8'h0c;

    // field positions
    localparam int SW_WDT_EN_BIT  = 0;
    localparam int FREQ_SEL_LSB   = 4;
    localparam int FREQ_SEL_MSB   = 6;
    localparam int PRI_READY_BIT  = 3;
    localparam int CLK_SEL_LSB    = 0;
    localparam int CLK_SEL_MSB    = 1;
    localparam int OSC_FAIL_BIT   = 7;
    localparam int TIMEOUT_N_BIT  = 3;

    // reset values
    localparam logic       SW_WDT_EN_RESET   = 1'b0;
    localparam logic [2:0] FREQ_SEL_RESET    = 3'h0;
    localparam logic [1:0] CLK_SEL_RESET     = 2'h0;
    localparam logic       TIMEOUT_N_RESET   = 1'b1;

    // system clock select encodings
    localparam logic [1:0] CLK_SEL_PRIMARY   = 2'h0;
    localparam logic [1:0] CLK_SEL_SECONDARY = 2'h1;

    // clock source states, gray along startup -> primary -> failsafe
    typedef enum logic [1:0] {
        ST_STARTUP   = 2'b00,
        ST_PRIMARY   = 2'b01,
        ST_FAILSAFE  = 2'b11,
        ST_ALTERNATE = 2'b10
    } clk_state_type;

endpackage

//--- level_sync.sv
// two-flop synchroniser for levels from outside the pclk domain
module level_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             pclk,
    input  wire logic             presetn,
    input  wire logic             clk_enable,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] stage1_reg;

    // ------------------------------------------------------------------
    // two stages, second read only
    // ------------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stage1_reg <= '0;
            sync_out   <= '0;
        end else if (clk_enable) begin
            stage1_reg <= async_in;
            sync_out   <= stage1_reg;
        end
    end
endmodule // level_sync

//--- clock_supervisor_watchdog.sv
module clock_supervisor_watchdog #(
    parameter int WDT_BASE_CYCLES = clock_supervisor_pkg::WDT_BASE_CYCLES
) (
    input  wire logic                                   pclk,
    input  wire logic                                   presetn,
    input  wire logic                                   clk_enable,
    input  wire logic                                   psel,
    input  wire logic                                   penable,
    input  wire logic                                   pwrite,
    input  wire logic [clock_supervisor_pkg::ADDR_W-1:0] paddr,
    input  wire logic [clock_supervisor_pkg::DATA_W-1:0] pwdata,
    output logic      [clock_supervisor_pkg::DATA_W-1:0] prdata,
    output logic                                        pready,
    output logic                                        pslverr,
    input  wire logic                                   primary_osc_clk,
    input  wire logic                                   secondary_osc_clk,
    input  wire logic                                   osc_startup_done,
    input  wire logic                                   cfg_watchdog_enable,
    input  wire logic [3:0]                             cfg_postscale_select,
    input  wire logic                                   two_speed_enable,
    input  wire logic                                   fail_monitor_enable,
    input  wire logic                                   sleep_instr,
    input  wire logic                                   clear_watchdog_instr,
    input  wire logic                                   wake_event,
    input  wire logic                                   power_managed_entry,
    output logic                                        clock_select_internal,
    output logic                                        primary_run_mode,
    output logic                                        internal_rc_enable,
    output logic                                        osc_fail_flag,
    output logic                                        watchdog_timeout
);
    import clock_supervisor_pkg::*;

    // ------------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------------
    logic                    sw_watchdog_enable_reg;
    logic [2:0]              internal_freq_select_reg;
    logic [1:0]              system_clock_select_reg;
    logic                    timeout_n_reg;
    logic                    freq_changed_reg;
    clk_state_type           state_reg, state_next;
    logic [2:0]              osc_sync;
    logic                    prim_sync, sec_sync, ost_sync;
    logic                    mon_clk_prev_reg;
    logic                    monitor_latch_reg;
    logic [SAMPLE_DIV_W-1:0] sample_div_reg;
    logic [31:0]             base_cnt_reg;
    logic [POSTSCALE_W-1:0]  postscale_reg;
    logic                    wdt_on, rc_on, mon_active, mon_clk;
    logic                    mon_fall, sample_rise, sample_fall;
    logic                    fail_pulse, wdt_clear, base_tick, tap_hit;
    logic                    pm_entry;
    logic                    apb_setup, apb_done, addr_ok;
    logic [POSTSCALE_W-1:0]  tap_last;
    logic [DATA_W-1:0]       read_word;

    // ------------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------------
    level_sync #(.WIDTH(3)) u_pin_sync (
        .pclk       (pclk),
        .presetn    (presetn),
        .clk_enable (clk_enable),
        .async_in   ({osc_startup_done, secondary_osc_clk, primary_osc_clk}),
        .sync_out   (osc_sync)
    );
    assign {ost_sync, sec_sync, prim_sync} = osc_sync;

    // ------------------------------------------------------------------
    // enables and event decode
    // ------------------------------------------------------------------
    // config enable overrides, software bit used only when it is off
    assign wdt_on   = cfg_watchdog_enable | sw_watchdog_enable_reg;
    // rc clock runs for watchdog or monitor, independently
    assign rc_on    = wdt_on | fail_monitor_enable;
    assign pm_entry = power_managed_entry | sleep_instr;
    // monitored source: secondary only when selected, else primary
    assign mon_clk  = (system_clock_select_reg == CLK_SEL_SECONDARY)
                      ? sec_sync : prim_sync;
    assign mon_active = fail_monitor_enable &
                        ((state_reg == ST_PRIMARY) |
                         ((state_reg == ST_ALTERNATE) &
                          (system_clock_select_reg == CLK_SEL_SECONDARY)));
    assign mon_fall    = mon_clk_prev_reg & ~mon_clk;
    assign sample_rise = rc_on & (sample_div_reg == SAMPLE_RISE_CNT);
    assign sample_fall = rc_on & (sample_div_reg == SAMPLE_FALL_CNT);
    // failure decided on sample fall, all in pclk domain
    assign fail_pulse  = mon_active & sample_fall
                         & monitor_latch_reg;
    assign wdt_clear   = sleep_instr | clear_watchdog_instr
                         | freq_changed_reg | fail_pulse;
    assign base_tick   = wdt_on & (base_cnt_reg == 32'(WDT_BASE_CYCLES - 1));
    assign tap_last    = POSTSCALE_W'((17'h1 << cfg_postscale_select) - 17'h1);
    assign tap_hit     = base_tick & (postscale_reg == tap_last);

    // ------------------------------------------------------------------
    // sample clock divider
    // ------------------------------------------------------------------
    // free running while rc clock enabled, divide by 64
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sample_div_reg <= '0;
        end else if (clk_enable && rc_on) begin
            sample_div_reg <= sample_div_reg + 6'h01;
        end
    end

    // ------------------------------------------------------------------
    // clock monitor latch
    // ------------------------------------------------------------------
    // set on device clock fall, cleared on sample rise; set wins
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mon_clk_prev_reg  <= 1'b0;
            monitor_latch_reg <= 1'b0;
        end else if (clk_enable) begin
            mon_clk_prev_reg <= mon_clk;
            if (mon_fall) begin
                monitor_latch_reg <= 1'b1;
            end else if (sample_rise) begin
                monitor_latch_reg <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------------
    // watchdog base counter and postscaler
    // ------------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            base_cnt_reg  <= '0;
            postscale_reg <= '0;
        end else if (clk_enable) begin
            if (wdt_clear || !wdt_on) begin
                base_cnt_reg  <= '0;
                postscale_reg <= '0;
            end else if (base_tick) begin
                base_cnt_reg  <= '0;
                postscale_reg <= tap_hit ? '0 : postscale_reg + 16'h0001;
            end else begin
                base_cnt_reg  <= base_cnt_reg + 32'h1;
            end
        end
    end

    // time-out pulse, one cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            watchdog_timeout <= 1'b0;
        end else if (clk_enable) begin
            watchdog_timeout <= tap_hit & ~wdt_clear;
        end
    end

    // ------------------------------------------------------------------
    // clock source state machine
    // ------------------------------------------------------------------
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            ST_STARTUP: begin
                if (pm_entry && system_clock_select_reg != CLK_SEL_PRIMARY)
                    state_next = ST_ALTERNATE;
                else if (ost_sync)
                    state_next = ST_PRIMARY;
            end
            ST_PRIMARY: begin
                if (fail_pulse)
                    state_next = ST_FAILSAFE;
                else if (pm_entry &&
                         system_clock_select_reg != CLK_SEL_PRIMARY)
                    state_next = ST_ALTERNATE;
                else if (wake_event && two_speed_enable)
                    state_next = ST_STARTUP;
            end
            ST_FAILSAFE: begin
                if (pm_entry)
                    state_next = (system_clock_select_reg == CLK_SEL_PRIMARY)
                                 ? ST_PRIMARY : ST_ALTERNATE;
            end
            ST_ALTERNATE: begin
                if (fail_pulse)
                    state_next = ST_FAILSAFE;
                else if (pm_entry &&
                         system_clock_select_reg == CLK_SEL_PRIMARY)
                    state_next = ST_PRIMARY;
            end
            default: state_next = ST_STARTUP;
        endcase
    end

    // reset always starts in the start-up state on the internal clock; start-up then keeps it only with two-speed or monitor enabled
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg <= ST_STARTUP;
        end else if (clk_enable) begin
            state_reg <= state_next;
        end
    end

    // ------------------------------------------------------------------
    // registered clock outputs
    // ------------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            clock_select_internal <= 1'b1;
            primary_run_mode      <= 1'b0;
            internal_rc_enable    <= 1'b0;
        end else if (clk_enable) begin
            case (state_next)
                ST_STARTUP:   clock_select_internal <= two_speed_enable
                                  | fail_monitor_enable;
                ST_FAILSAFE:  clock_select_internal <= 1'b1;
                ST_ALTERNATE: clock_select_internal <=
                                  system_clock_select_reg != CLK_SEL_SECONDARY;
                default:      clock_select_internal <= 1'b0;
            endcase
            primary_run_mode   <= state_next == ST_PRIMARY;
            internal_rc_enable <= rc_on;
        end
    end

    // ------------------------------------------------------------------
    // apb slave, one wait state per access
    // ------------------------------------------------------------------
    assign apb_setup = psel & penable & ~pready;
    assign apb_done  = psel & penable & pready;
    assign addr_ok   = (paddr == WDT_CTRL_OFFSET) | (paddr == OSC_CTRL_OFFSET)
                       | (paddr == IRQ2_OFFSET) | (paddr == RESET_CAUSE_OFFSET);

    // read mux, unused bits zero
    always_comb begin
        read_word = '0;
        case (paddr)
            WDT_CTRL_OFFSET:
                read_word[SW_WDT_EN_BIT] = sw_watchdog_enable_reg;
            OSC_CTRL_OFFSET: begin
                read_word[FREQ_SEL_MSB:FREQ_SEL_LSB] =
                    internal_freq_select_reg;
                read_word[PRI_READY_BIT] = state_reg == ST_PRIMARY;
                read_word[CLK_SEL_MSB:CLK_SEL_LSB] = system_clock_select_reg;
            end
            IRQ2_OFFSET:
                read_word[OSC_FAIL_BIT] = osc_fail_flag;
            RESET_CAUSE_OFFSET:
                read_word[TIMEOUT_N_BIT] = timeout_n_reg;
            default: read_word = '0;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= '0;
        end else if (clk_enable) begin
            pready  <= apb_setup;
            pslverr <= apb_setup & ~addr_ok;
            prdata  <= (apb_setup && !pwrite) ? read_word : '0;
        end
    end

    // ------------------------------------------------------------------
    // software registers
    // ------------------------------------------------------------------
    // hardware never edits these fields, so only APB writes change them from reset values
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sw_watchdog_enable_reg   <= SW_WDT_EN_RESET;
            internal_freq_select_reg <= FREQ_SEL_RESET;
            system_clock_select_reg  <= CLK_SEL_RESET;
            freq_changed_reg         <= 1'b0;
        end else if (clk_enable) begin
            freq_changed_reg <= 1'b0;
            if (apb_done && pwrite && paddr == WDT_CTRL_OFFSET)
                sw_watchdog_enable_reg <= pwdata[SW_WDT_EN_BIT];
            if (apb_done && pwrite && paddr == OSC_CTRL_OFFSET) begin
                internal_freq_select_reg <= pwdata[FREQ_SEL_MSB:FREQ_SEL_LSB];
                system_clock_select_reg  <= pwdata[CLK_SEL_MSB:CLK_SEL_LSB];
                freq_changed_reg <= pwdata[FREQ_SEL_MSB:FREQ_SEL_LSB]
                                    != internal_freq_select_reg;
            end
        end
    end

    // fail flag: hardware set wins over software clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            osc_fail_flag <= 1'b0;
        end else if (clk_enable) begin
            if (fail_pulse)
                osc_fail_flag <= 1'b1;
            else if (apb_done && pwrite && paddr == IRQ2_OFFSET)
                osc_fail_flag <= pwdata[OSC_FAIL_BIT];
        end
    end

    // reset cause: time-out drops the bit, software sets it again
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            timeout_n_reg <= TIMEOUT_N_RESET;
        end else if (clk_enable) begin
            if (watchdog_timeout)
                timeout_n_reg <= 1'b0;
            else if (apb_done && pwrite && paddr == RESET_CAUSE_OFFSET)
                timeout_n_reg <= pwdata[TIMEOUT_N_BIT];
        end
    end

    // ------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_wdt_upper_zero: assert property (
        (clk_enable && apb_setup && !pwrite && paddr == WDT_CTRL_OFFSET)
        |=> prdata[31:1] == '0 && pready)
        else $error("watchdog control upper bits not zero");
    a_wdt_clear_counts: assert property (
        (clk_enable && wdt_clear)
        |=> base_cnt_reg == '0 && postscale_reg == '0)
        else $error("watchdog not cleared");
    a_rc_follows_wdt: assert property (
        (clk_enable && wdt_on) |=> internal_rc_enable)
        else $error("rc clock off while watchdog on");
    a_rc_follows_mon: assert property (
        (clk_enable && fail_monitor_enable && !wdt_on) |=> internal_rc_enable)
        else $error("rc clock off while monitor on");
    a_sample_wrap: assert property (
        (clk_enable && rc_on && sample_div_reg == SAMPLE_FALL_CNT)
        |=> sample_div_reg == 6'h00)
        else $error("sample divider not 64");
    a_latch_clear: assert property (
        (clk_enable && sample_rise && !mon_fall) |=> !monitor_latch_reg)
        else $error("monitor latch not cleared");
    a_fail_reaction: assert property (
        (clk_enable && fail_pulse)
        |=> osc_fail_flag && clock_select_internal
            && state_reg == ST_FAILSAFE && postscale_reg == '0)
        else $error("clock failure not handled");
    a_failsafe_hold: assert property (
        (state_reg == ST_FAILSAFE && !(clk_enable && pm_entry))
        |=> state_reg == ST_FAILSAFE)
        else $error("fail-safe left without cause");
    a_ost_switch: assert property (
        (clk_enable && state_reg == ST_STARTUP && ost_sync && !pm_entry)
        |=> primary_run_mode && !clock_select_internal)
        else $error("no switch to primary after start-up");
    a_wdt_time_out: assert property (
        (clk_enable && tap_hit && !wdt_clear)
        |=> watchdog_timeout ##1 !watchdog_timeout)
        else $error("time-out pulse wrong");

    c_fail_seen:    cover property (clk_enable && fail_pulse);
    c_startup_done: cover property (state_reg == ST_STARTUP
                                    ##1 state_reg == ST_PRIMARY);
    c_timeout:      cover property (watchdog_timeout);
    c_apb_write:    cover property (apb_done && pwrite);

endmodule // clock_supervisor_watchdog

//--- osc_model.sv
// crystal source with a start-up timer; stands still while stopped
module osc_model (
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic run,
    output logic      osc_clk,
    output logic      startup_done
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [5:0] cnt_reg;
    logic       done_reg;
    // low bits make a slow clock, bit 5 ends the start-up delay
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            {done_reg, cnt_reg} <= 7'h00;
        else if (run)
            {done_reg, cnt_reg} <= {done_reg | cnt_reg[5], cnt_reg + 6'h01};
    end
    assign osc_clk = cnt_reg[1];
    assign startup_done = done_reg;
endmodule // osc_model

//--- test_clock_supervisor_watchdog.sv
module test_clock_supervisor_watchdog;
    timeunit 1ns;
    timeprecision 1ns;
    logic        pclk, rst_n, psel, pen, pwr, run, osc, done, cfg, two;
    logic        mon, slp, clr, pm, er, rdy, err, sel, pri, rc, fail, tmo, wk;
    logic [3:0]  ps;
    logic [7:0]  pa;
    logic [31:0] pwd, prd, rd;
    int          errors, n_checks, c;
    logic [7:0]  rows [9][3] = '{'{8'h00, 8'hff, 8'h01},
        '{8'h00, 8'h00, 8'h00}, '{8'h04, 8'h7b, 8'h73}, '{8'h04, 8'h00, 8'h00},
        '{8'h08, 8'h80, 8'h80}, '{8'h08, 8'h00, 8'h00}, '{8'h0c, 8'h00, 8'h00},
        '{8'h0c, 8'h08, 8'h08}, '{8'h10, 8'h5a, 8'h00}};
    wire  [3:0]  sigs = {rdy, tmo, fail, pri};
    osc_model osc_u (.pclk(pclk), .presetn(rst_n), .run(run),
        .osc_clk(osc), .startup_done(done));
    clock_supervisor_watchdog #(.WDT_BASE_CYCLES(8)) dut_u (.pclk(pclk),
        .presetn(rst_n), .clk_enable(1'b1), .psel(psel), .penable(pen),
        .pwrite(pwr), .paddr(pa), .pwdata(pwd), .prdata(prd), .pready(rdy),
        .pslverr(err), .primary_osc_clk(osc), .secondary_osc_clk(1'b0),
        .osc_startup_done(done), .cfg_watchdog_enable(cfg),
        .cfg_postscale_select(ps), .two_speed_enable(two),
        .fail_monitor_enable(mon), .sleep_instr(slp),
        .clear_watchdog_instr(clr), .wake_event(wk),
        .power_managed_entry(pm), .clock_select_internal(sel),
        .primary_run_mode(pri), .internal_rc_enable(rc),
        .osc_fail_flag(fail), .watchdog_timeout(tmo));
    task check(input logic [32:0] seen, input logic [32:0] exp);
        n_checks++;
        if (seen !== exp) begin
            errors++;
            $display("Error %0t: saw %h want %h", $time, seen, exp);
        end
    endtask
    task final_report;
        if (errors == 0 && n_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    // bounded wait on one observed signal
    task wait_on(input int k, input int lim);
        c = 0;
        do begin
            @(posedge pclk);
            c++;
        end while (sigs[k] !== 1'b1 && c < lim);
        if (sigs[k] !== 1'b1) begin
            errors++;
            final_report;
        end
    endtask
    task apb(input logic w, input logic [7:0] a, input logic [7:0] d);
        {psel, pwr, pa, pwd} <= {1'b1, w, a, 24'h0, d};
        @(posedge pclk);
        pen <= 1'b1;
        wait_on(3, 20);
        {er, rd} = {err, prd};
        {psel, pen} <= 2'b00;
        @(posedge pclk);
    endtask
    task pulse(input int k);
        {pm, slp, clr} <= 3'h1 << k;
        @(posedge pclk);
        {pm, slp, clr} <= 3'h0;
    endtask
    initial begin
        pclk = 1'b0;
        forever #50 pclk = ~pclk;
    end
    initial begin
        {rst_n, psel, pen, pwr, run, cfg, pm, slp, clr, wk, pa, pwd, ps} = '0;
        {two, mon} = 2'b11;
        repeat (5) @(posedge pclk);
        check({sel, pri, rc, fail, tmo, rdy}, 6'h20);
        rst_n <= 1'b1;
        repeat (2) @(posedge pclk);
        check(rc, 1'b1);
        foreach (rows[k]) begin
            apb(1'b1, rows[k][0], rows[k][1]);
            apb(1'b0, rows[k][0], 8'h00);
            check({er, rd},
                  {rows[k][0] == 8'h10, 24'h0, rows[k][2]});
        end
        run <= 1'b1;
        wait_on(0, 99);
        check({sel, pri}, 2'b01);
        apb(1'b0, 8'h04, 8'h00);
        check(rd, 32'h08);
        run <= 1'b0;
        wait_on(1, 140);
        check({sel, pri}, 2'b10);
        apb(1'b0, 8'h04, 8'h00);
        check(rd, 32'h00);
        run <= 1'b1;
        repeat (200) @(posedge pclk);
        check(sel, 1'b1);
        pulse(2);
        wait_on(0, 20);
        mon <= 1'b0;
        apb(1'b1, 8'h00, 8'h01);
        @(posedge pclk);
        check(rc, 1'b1);
        for (int s = 0; s < 3; s++) begin
            ps <= s[3:0];
            pulse(s % 2);
            wait_on(2, 99);
            check(c + 2 > (8 << s) && c < (8 << s) + 3,
                  1'b1);
        end
        apb(1'b1, 8'h00, 8'h00);
        cfg <= 1'b1;
        wait_on(2, 99);
        check(c < 40, 1'b1);
        // wake from primary run restarts two-speed for one cycle
        wk <= 1'b1;
        @(posedge pclk);
        wk <= 1'b0;
        @(posedge pclk);
        check({sel, pri}, 2'b10);
        // mid-run reset: internal clock, flag cleared, then primary again
        rst_n <= 1'b0;
        repeat (2) @(posedge pclk);
        check({sel, pri, fail, tmo}, 4'b1000);
        rst_n <= 1'b1;
        wait_on(0, 99);
        check(sel, 1'b0);
        apb(1'b0, 8'h04, 8'h00);
        check(rd, 32'h08);
        final_report;
    end
endmodule // test_clock_supervisor_watchdog
